// ==== inc/smd_regs.vh ====
// Register offsets, field codes and reset values of the shift and move decoder
`ifndef SMD_REGS_VH
`define SMD_REGS_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define SMD_OFF_INSTR    8'h00
`define SMD_OFF_OPERAND  8'h04
`define SMD_OFF_RESULT   8'h08
`define SMD_OFF_FLAGS    8'h0C
`define SMD_OFF_STATUS   8'h10
`define SMD_RF_SEL_BIT   6
`define SMD_RF_HI_BIT    7

// ****************************************
// Flag byte layout and reset values
// ****************************************
`define SMD_FLG_X        4
`define SMD_FLG_N        3
`define SMD_FLG_Z        2
`define SMD_FLG_V        1
`define SMD_FLG_C        0
`define SMD_FLAGS_RST    5'h00
`define SMD_WORD_RST     32'h0000_0000
`define SMD_OP_RST       16'h0000

// ****************************************
// Opcode field codes
// ****************************************
`define SMD_SHIFT_NIB    4'hE
`define SMD_RSHIFT_TAG   2'h1
`define SMD_MSHIFT_TAG   3'h1
`define SMD_FSTORE_OP    10'h10B
`define SMD_MODE_DREG    3'h0
`define SMD_MODE_AREG    3'h1
`define SMD_MODE_IND     3'h2
`define SMD_MODE_IDX     3'h6
`define SMD_MODE_EXT     3'h7
`define SMD_EXT_ABSL     3'h1
`define SMD_EXT_IMM      3'h4
`define SMD_IMM_ZERO_CNT 6'h08

// ****************************************
// Internal size codes and move size field
// ****************************************
`define SMD_SZ_B         2'h0
`define SMD_SZ_W         2'h1
`define SMD_SZ_L         2'h2
`define SMD_MV_B         2'h1
`define SMD_MV_W         2'h3
`define SMD_MV_L         2'h2

`endif

// ==== verif/smd_decode_properties.sv ====
// Bus and execution timing checker for the shift and move decoder
`timescale 1ns/1ps

module smd_decode_chk (
	// Clock and reset
	input wire logic        i_clk,
	input wire logic        i_rst,
	// APB request
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [7:0]  i_paddr,
	input wire logic [31:0] i_pwdata,
	// APB answer and status
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic        o_busy,
	input wire logic        o_illegal
);
	// ****
	// Properties
	// ****
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	property p_err_rdy; o_pslverr |-> o_pready; endproperty
	property p_rdy_acc; o_pready |-> i_psel && i_penable; endproperty
	property p_wr_fast; i_psel && i_penable && i_pwrite && !o_busy |-> o_pready; endproperty
	property p_rd_wait;
		$rose(i_penable) && i_psel && !i_pwrite && !o_busy |-> !o_pready ##1 !o_pready ##1 o_pready;
	endproperty
	// Execution runs three busy cycles, then frees the bus
	property p_exec;
		i_psel && i_penable && i_pwrite && o_pready && i_paddr == 8'h00 |=> o_busy [*3] ##1 !o_busy;
	endproperty
	property p_busy_max; $rose(o_busy) |-> ##[1:4] !o_busy; endproperty
	property p_ill_upd; $rose(o_illegal) |-> $fell(o_busy); endproperty
	property p_err_map;
		o_pready && (i_paddr[1:0] != 2'h0 || (i_paddr > 8'h10 && i_paddr < 8'h40) || i_paddr > 8'h7C)
			|-> o_pslverr;
	endproperty
	property p_rst; $past(i_rst) |-> !o_busy && !o_illegal && o_prdata == 32'h0; endproperty

	a_err_rdy: assert property (p_err_rdy) else $error("error without ready"); // bus contract
	a_rdy_acc: assert property (p_rdy_acc) else $error("ready outside access"); // bus contract
	a_wr_fast: assert property (p_wr_fast) else $error("idle write not at once"); // bus contract
	a_rd_wait: assert property (p_rd_wait) else $error("read wait count wrong"); // bus contract
	a_exec: assert property (p_exec) else $error("execution length wrong");
	a_busy_max: assert property (p_busy_max) else $error("busy too long");
	a_ill_upd: assert property (p_ill_upd) else $error("illegal flag off step");
	a_err_map: assert property (p_err_map) else $error("unmapped not refused"); // bus contract
	a_rst: assert property (p_rst) else $error("reset state wrong"); // reset

	// Main scenarios reached
	c_exec: cover property (p_exec);
	c_err: cover property (o_pslverr);
	c_ill: cover property ($rose(o_illegal));
endmodule // smd_decode_chk

// ==== verif/smd_fetch_model.sv ====
// APB master standing in for the fetch and operand path
`timescale 1ns/1ps

module smd_fetch_model (
	// Clock
	input  wire logic        i_clk,
	// APB request
	output logic             o_psel,
	output logic             o_penable,
	output logic             o_pwrite,
	output logic      [7:0]  o_paddr,
	output logic      [31:0] o_pwdata,
	// APB answer
	input  wire logic [31:0] i_prdata,
	input  wire logic        i_pready,
	input  wire logic        i_pslverr
);
	// ****
	// Bus master
	// ****
	// Idle bus from time zero
	initial begin
		o_psel = 1'h0;
		o_penable = 1'h0;
		o_pwrite = 1'h0;
		o_paddr = 8'h00;
		o_pwdata = 32'h0;
	end

	// Request held until ready is sampled or 50 cycles pass; released lines invert so stale data never matches
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e, output logic t);
		int n;
		@(posedge i_clk);
		o_psel <= 1'h1;
		o_pwrite <= w;
		o_paddr <= a;
		o_pwdata <= d;
		@(posedge i_clk);
		o_penable <= 1'h1;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (i_pready !== 1'h1 && n < 50);
		t = (n >= 50);
		q = i_prdata;
		e = i_pslverr;
		o_psel <= 1'h0;
		o_penable <= 1'h0;
		o_paddr <= ~a;
		o_pwdata <= ~d;
	endtask
endmodule // smd_fetch_model

// ==== verif/tb_top.sv ====
// Self-checking bench for the shift and move decoder
`timescale 1ns/1ps

module tb_top;
	// ****
	// Wires, counters and table
	// ****
	logic        i_clk, i_rst, e;
	logic [31:0] q;
	wire         psel, pen, pwr, rdy, err, busy, ill;
	wire  [7:0]  paddr;
	wire  [31:0] pwdata, prdata;
	int          errors, check_count, n;

	typedef struct packed {
		logic [15:0] op;
		logic [31:0] d1, d2;
		logic [4:0]  pre, fl;
		logic [31:0] res;
		logic        ill;
	} smd_row_t;
	// Opcode, operand, count or address reg, flags before, flags after, result, illegal
	smd_row_t rows [14] = '{
		'{16'hE309, 32'h81, 32'h0, 5'h00, 5'h11, 32'h02, 1'h0},
		'{16'hE049, 32'h7F00, 32'h0, 5'h1F, 5'h00, 32'h7F, 1'h0},
		'{16'hE5A9, 32'h4000_0000, 32'h41, 5'h00, 5'h08, 32'h8000_0000, 1'h0},
		'{16'hE5A9, 32'h0, 32'h40, 5'h1F, 5'h14, 32'h0, 1'h0},
		'{16'hE429, 32'h05, 32'h03, 5'h00, 5'h15, 32'h0, 1'h0},
		'{16'h1601, 32'h80, 32'h0, 5'h1F, 5'h18, 32'h80, 1'h0},
		'{16'h363C, 32'h0, 32'h0, 5'h00, 5'h04, 32'h0, 1'h0},
		'{16'h3441, 32'h8000, 32'h0, 5'h0A, 5'h0A, 32'hFFFF_8000, 1'h0},
		'{16'hE3D1, 32'hC001, 32'h0, 5'h00, 5'h19, 32'h8002, 1'h0},
		'{16'h42C3, 32'h0, 32'h0, 5'h1F, 5'h1F, 32'h1F, 1'h0},
		'{16'h1609, 32'h0, 32'h0, 5'h05, 5'h05, 32'h0, 1'h1},
		'{16'h29C1, 32'h0, 32'h0, 5'h05, 5'h05, 32'h0, 1'h1},
		'{16'hE3C1, 32'h0, 32'h0, 5'h05, 5'h05, 32'h0, 1'h1},
		'{16'h2609, 32'h0, 32'h8000_0000, 5'h00, 5'h08, 32'h8000_0000, 1'h0}
	};

	// Clock at 100 ns period
	initial begin
		i_clk = 1'h0;
		forever #50 i_clk = ~i_clk;
	end

	smd_decode u_smd_decode (.i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(rdy),
		.o_pslverr(err), .o_busy(busy), .o_illegal(ill));
	smd_fetch_model u_smd_fetch_model (.i_clk(i_clk), .o_psel(psel), .o_penable(pen), .o_pwrite(pwr),
		.o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata), .i_pready(rdy), .i_pslverr(err));

	// ****
	// Tasks
	// ****
	task test_done;
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] g, input logic [31:0] x);
		check_count++;
		if (g !== x) begin
			errors++;
			$display("BAD %s exp %h got %h", nm, x, g);
		end
	endtask

	// One bus cycle; a hung slave ends the run
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic t;
		u_smd_fetch_model.xfer(w, a, d, q, e, t);
		if (t) begin
			errors++;
			test_done;
		end
	endtask

	// Reset values, refused address, read-only result
	task t_reset;
		bus(0, 8'h0C, 32'h0);
		chk("flags", q, 32'h0);
		bus(0, 8'h20, 32'h0);
		chk("err", {31'h0, e}, 32'h1);
		chk("rdat", q, 32'h0);
		bus(1, 8'h08, 32'hFFFF);
		bus(0, 8'h08, 32'h0);
		chk("result", q, 32'h0);
		$display("t_reset done");
	endtask

	// Each row: load registers, execute, judge flags, result and refusal
	task t_table;
		foreach (rows[i]) begin
			bus(1, 8'h44, rows[i].d1);
			bus(1, 8'h48, rows[i].d2);
			bus(1, 8'h64, rows[i].d2);
			bus(1, 8'h04, rows[i].d1);
			bus(1, 8'h0C, {27'h0, rows[i].pre});
			bus(1, 8'h00, {16'h0, rows[i].op});
			n = 0;
			do begin
				bus(0, 8'h10, 32'h0);
				n++;
			end while (q[0] !== 1'h1 && n < 20);
			if (n >= 20) begin
				errors++;
				test_done;
			end
			chk("status", {31'h0, q[1]}, {31'h0, rows[i].ill});
			chk("ill", {31'h0, ill}, {31'h0, rows[i].ill});
			bus(0, 8'h0C, 32'h0);
			chk("flags", q, {27'h0, rows[i].fl});
			bus(0, 8'h08, 32'h0);
			if (!rows[i].ill)
				chk("result", q, rows[i].res);
			// Register shifts write back into data_reg 1, upper bits were zero
			if (rows[i].op[15:12] == 4'hE && rows[i].op[7:6] != 2'h3) begin
				bus(0, 8'h44, 32'h0);
				chk("dreg", q, rows[i].res);
			end
			// Address load fills the whole address_reg 2
			if (rows[i].op == 16'h3441) begin
				bus(0, 8'h68, 32'h0);
				chk("areg", q, rows[i].res);
			end
		end
		$display("t_table done");
	endtask

	// Main sequence
	initial begin
		errors = 0;
		check_count = 0;
		i_rst = 1'h1;
		repeat (3) @(posedge i_clk);
		i_rst <= 1'h0;
		t_reset;
		t_table;
		test_done;
	end
endmodule // tb_top

bind smd_decode smd_decode_chk u_smd_decode_chk (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel),
	.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
	.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_busy(o_busy), .o_illegal(o_illegal));

// ==== verilog/smd_decode.v ====
// Shift and move instruction decoder and executor with APB register access
`timescale 1ns/1ps
`include "smd_regs.vh"

module smd_decode (
	// Clock and reset
	input  wire        i_clk,
	input  wire        i_rst,
	// APB slave
	input  wire        i_psel,
	input  wire        i_penable,
	input  wire        i_pwrite,
	input  wire [7:0]  i_paddr,
	input  wire [31:0] i_pwdata,
	output wire [31:0] o_prdata,
	output wire        o_pready,
	output wire        o_pslverr,
	// Execution status
	output wire        o_busy,
	output wire        o_illegal
);

	// ****************************************
	// States
	// ****************************************
	localparam [5:0] S_IDLE   = 6'h01;
	localparam [5:0] S_BUSRD  = 6'h02;
	localparam [5:0] S_BUSACK = 6'h04;
	localparam [5:0] S_AUX    = 6'h08;
	localparam [5:0] S_OPD    = 6'h10;
	localparam [5:0] S_EXEC   = 6'h20;

	reg  [5:0]  state_ff;
	reg  [5:0]  nxt_state;
	reg  [15:0] op_ff;
	reg  [31:0] ext_ff;
	reg  [31:0] result_ff;
	reg  [4:0]  flags_ff;
	reg  [31:0] aux_ff;
	reg  [31:0] prdata_ff;
	reg         done_ff;
	reg         illegal_ff;
	reg  [4:0]  kind_ff;

	// ****************************************
	// Helper functions
	// ****************************************
	function [31:0] sz_mask;
		input [1:0] sz;
		begin
			case (sz)
				`SMD_SZ_B: sz_mask = 32'h0000_00FF;
				`SMD_SZ_W: sz_mask = 32'h0000_FFFF;
				default:   sz_mask = 32'hFFFF_FFFF;
			endcase
		end
	endfunction

	function msb_of;
		input [31:0] v;
		input [1:0]  sz;
		begin
			case (sz)
				`SMD_SZ_B: msb_of = v[7];
				`SMD_SZ_W: msb_of = v[15];
				default:   msb_of = v[31];
			endcase
		end
	endfunction

	// Memory alterable: indirect through indexed, or absolute short/long
	function mem_alt;
		input [2:0] mode;
		input [2:0] rg;
		begin
			mem_alt = ((mode >= `SMD_MODE_IND) && (mode <= `SMD_MODE_IDX)) ||
				((mode == `SMD_MODE_EXT) && (rg <= `SMD_EXT_ABSL));
		end
	endfunction

	// Any valid source: all modes up to immediate
	function src_ok;
		input [2:0] mode;
		input [2:0] rg;
		begin
			src_ok = (mode != `SMD_MODE_EXT) || (rg <= `SMD_EXT_IMM);
		end
	endfunction

	// ****************************************
	// Opcode decode
	// ****************************************
	wire [2:0] f_hi_reg  = op_ff[11:9];
	wire [2:0] f_hi_mode = op_ff[8:6];
	wire [2:0] f_lo_mode = op_ff[5:3];
	wire [2:0] f_lo_reg  = op_ff[2:0];
	wire [1:0] f_size    = op_ff[13:12];
	wire       dir_bit   = op_ff[8];
	wire       cnt_src   = op_ff[5];

	wire shift_grp = (op_ff[15:12] == `SMD_SHIFT_NIB);
	wire k_rshift  = shift_grp && (op_ff[4:3] == `SMD_RSHIFT_TAG) && (op_ff[7:6] != 2'h3);
	wire k_mshift  = shift_grp && (op_ff[7:6] == 2'h3) && (f_hi_reg == `SMD_MSHIFT_TAG);
	wire k_fstore  = (op_ff[15:6] == `SMD_FSTORE_OP);
	wire move_grp  = (op_ff[15:14] == 2'h0) && (f_size != 2'h0);
	wire k_aload   = move_grp && (f_hi_mode == `SMD_MODE_AREG);
	wire k_move    = move_grp && (f_hi_mode != `SMD_MODE_AREG);

	wire dst_dalt  = (f_hi_mode == `SMD_MODE_DREG) || mem_alt(f_hi_mode, f_hi_reg);
	wire lo_dalt   = (f_lo_mode == `SMD_MODE_DREG) || mem_alt(f_lo_mode, f_lo_reg);

	// Per-kind legality of the addressing modes
	wire ok_mshift = mem_alt(f_lo_mode, f_lo_reg);
	wire ok_move   = dst_dalt && src_ok(f_lo_mode, f_lo_reg) &&
		!((f_size == `SMD_MV_B) && (f_lo_mode == `SMD_MODE_AREG));
	wire ok_aload  = src_ok(f_lo_mode, f_lo_reg) && (f_size != `SMD_MV_B);
	wire legal     = k_rshift || (k_mshift && ok_mshift) || (k_move && ok_move) ||
		(k_aload && ok_aload) || (k_fstore && lo_dalt);

	// Operand size in internal code
	reg [1:0] sz;
	always @* begin
		sz = `SMD_SZ_W;
		if (k_rshift) begin
			sz = op_ff[7:6];
		end else if (move_grp) begin
			case (f_size)
				`SMD_MV_B: sz = `SMD_SZ_B;
				`SMD_MV_W: sz = `SMD_SZ_W;
				default:   sz = `SMD_SZ_L;
			endcase
		end
	end

	// Source operand comes from the operand register for memory modes
	wire src_dreg = (f_lo_mode == `SMD_MODE_DREG);
	wire src_areg = (f_lo_mode == `SMD_MODE_AREG);
	wire use_ext  = k_mshift || (move_grp && !src_dreg && !src_areg);

	// ****************************************
	// Register file hookup
	// ****************************************
	reg  [3:0]  rf_raddr;
	reg         rf_we;
	reg  [3:0]  rf_waddr;
	reg  [31:0] rf_wdata;
	wire [31:0] rf_rdata;

	smd_regfile #(
		.WIDTH (32),
		.DEPTH (16),
		.AW    (4)
	) u_rf (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_we    (rf_we),
		.i_waddr (rf_waddr),
		.i_wdata (rf_wdata),
		.i_raddr (rf_raddr),
		.o_rdata (rf_rdata)
	);

	// ****************************************
	// APB decode
	// ****************************************
	wire acc     = i_psel && i_penable;
	wire is_rf   = i_paddr[`SMD_RF_SEL_BIT] && !i_paddr[`SMD_RF_HI_BIT] && (i_paddr[1:0] == 2'h0);
	wire is_csr  = (i_paddr == `SMD_OFF_INSTR) || (i_paddr == `SMD_OFF_OPERAND) ||
		(i_paddr == `SMD_OFF_RESULT) || (i_paddr == `SMD_OFF_FLAGS) || (i_paddr == `SMD_OFF_STATUS);
	wire mapped  = is_rf || is_csr;
	wire idle    = state_ff[0];
	wire wr_take = idle && acc && i_pwrite;

	// When idle, writes finish in their first access cycle, reads two cycles later
	assign o_pready  = wr_take || state_ff[2];
	assign o_pslverr = o_pready && !mapped;
	assign o_prdata  = prdata_ff;
	assign o_busy    = !idle;
	assign o_illegal = illegal_ff;

	reg [31:0] csr_rdata;
	always @* begin
		case (i_paddr)
			`SMD_OFF_INSTR:   csr_rdata = {16'h0000, op_ff};
			`SMD_OFF_OPERAND: csr_rdata = ext_ff;
			`SMD_OFF_RESULT:  csr_rdata = result_ff;
			`SMD_OFF_FLAGS:   csr_rdata = {27'h0, flags_ff};
			`SMD_OFF_STATUS:  csr_rdata = {23'h0, kind_ff, 1'b0, !idle, illegal_ff, done_ff};
			default:          csr_rdata = 32'h0000_0000;
		endcase
	end

	// ****************************************
	// Shift count and shifter
	// ****************************************
	reg [5:0] cnt;
	always @* begin
		if (k_mshift) begin
			cnt = 6'h01;
		end else if (cnt_src) begin
			cnt = aux_ff[5:0];
		end else if (f_hi_reg == 3'h0) begin
			cnt = `SMD_IMM_ZERO_CNT;
		end else begin
			cnt = {3'h0, f_hi_reg};
		end
	end

	// Operand is live register read data or the operand register
	wire [31:0] opd   = use_ext ? ext_ff : rf_rdata;
	wire [31:0] mask  = sz_mask(sz);
	wire [31:0] vmask = opd & mask;
	// Wide shifters so counts up to 63 drain cleanly to zero
	wire [63:0] lsh   = {32'h0, vmask} << cnt;
	wire [63:0] rsh   = {vmask, 32'h0} >> cnt;

	reg         sh_out;
	reg  [31:0] sh_res;
	always @* begin
		if (dir_bit) begin
			sh_res = lsh[31:0] & mask;
			case (sz)
				`SMD_SZ_B: sh_out = lsh[8];
				`SMD_SZ_W: sh_out = lsh[16];
				default:   sh_out = lsh[32];
			endcase
		end else begin
			sh_res = rsh[63:32];
			sh_out = rsh[31];
		end
	end

	// ****************************************
	// Execute: write-back value and flags
	// ****************************************
	reg [31:0] ex_val;
	reg [4:0]  ex_flags;
	always @* begin
		rf_we    = 1'b0;
		rf_waddr = 4'h0;
		rf_wdata = 32'h0000_0000;
		ex_val   = 32'h0000_0000;
		ex_flags = flags_ff;
		if (state_ff[5] && legal) begin
			if (k_rshift || k_mshift) begin
				ex_val = sh_res;
				ex_flags[`SMD_FLG_X] = (cnt == 6'h0) ? flags_ff[`SMD_FLG_X] : sh_out;
				ex_flags[`SMD_FLG_C] = (cnt == 6'h0) ? 1'b0 : sh_out;
				ex_flags[`SMD_FLG_N] = msb_of(sh_res, sz);
				ex_flags[`SMD_FLG_Z] = (sh_res == 32'h0);
				ex_flags[`SMD_FLG_V] = 1'b0;
				rf_we    = k_rshift;
				rf_waddr = {1'b0, f_lo_reg};
				rf_wdata = (opd & ~mask) | sh_res;
			end else if (k_move) begin
				ex_val = vmask;
				ex_flags[`SMD_FLG_N] = msb_of(vmask, sz);
				ex_flags[`SMD_FLG_Z] = (vmask == 32'h0);
				ex_flags[`SMD_FLG_V] = 1'b0;
				ex_flags[`SMD_FLG_C] = 1'b0;
				rf_we    = (f_hi_mode == `SMD_MODE_DREG);
				rf_waddr = {1'b0, f_hi_reg};
				rf_wdata = (aux_ff & ~mask) | vmask;
			end else if (k_aload) begin
				// Whole address register written; flags kept
				ex_val   = (sz == `SMD_SZ_W) ? {{16{opd[15]}}, opd[15:0]} : opd;
				rf_we    = 1'b1;
				rf_waddr = {1'b1, f_hi_reg};
				rf_wdata = ex_val;
			end else begin
				// Flag byte zero-extended to a word
				ex_val   = {27'h0, flags_ff};
				rf_we    = (f_lo_mode == `SMD_MODE_DREG);
				rf_waddr = {1'b0, f_lo_reg};
				rf_wdata = {aux_ff[31:16], ex_val[15:0]};
			end
		end else if (wr_take && is_rf) begin
			rf_we    = 1'b1;
			rf_waddr = i_paddr[5:2];
			rf_wdata = i_pwdata;
		end
	end

	// Read address: bus index, then aux register, then operand register
	always @* begin
		case (state_ff)
			S_IDLE:  rf_raddr = i_paddr[5:2];
			S_AUX:   rf_raddr = {1'b0, k_fstore ? f_lo_reg : f_hi_reg};
			S_OPD:   rf_raddr = {src_areg && move_grp, f_lo_reg}; // Shift register field always names a data reg
			default: rf_raddr = 4'h0;
		endcase
	end

	// ****************************************
	// Sequencer
	// ****************************************
	// Bus accesses stall while an instruction runs so writes never collide
	always @* begin
		case (state_ff)
			S_IDLE: begin
				if (wr_take && (i_paddr == `SMD_OFF_INSTR)) begin
					nxt_state = S_AUX;
				end else if (acc && !i_pwrite) begin
					nxt_state = S_BUSRD;
				end else begin
					nxt_state = S_IDLE;
				end
			end
			S_BUSRD:  nxt_state = S_BUSACK;
			S_BUSACK: nxt_state = S_IDLE;
			S_AUX:    nxt_state = S_OPD;
			S_OPD:    nxt_state = S_EXEC;
			S_EXEC:   nxt_state = S_IDLE;
			default:  nxt_state = S_IDLE;
		endcase
	end

	// ****************************************
	// Registers
	// ****************************************
	always @(posedge i_clk) begin
		if (i_rst) begin
			state_ff   <= S_IDLE;
			op_ff      <= `SMD_OP_RST;
			ext_ff     <= `SMD_WORD_RST;
			result_ff  <= `SMD_WORD_RST;
			flags_ff   <= `SMD_FLAGS_RST;
			aux_ff     <= `SMD_WORD_RST;
			prdata_ff  <= `SMD_WORD_RST;
			done_ff    <= 1'b0;
			illegal_ff <= 1'b0;
			kind_ff    <= 5'h00;
		end else begin
			state_ff <= nxt_state;
			// Software side of the control registers
			if (wr_take && (i_paddr == `SMD_OFF_INSTR)) begin
				op_ff   <= i_pwdata[15:0];
				done_ff <= 1'b0;
			end
			if (wr_take && (i_paddr == `SMD_OFF_OPERAND)) begin
				ext_ff <= i_pwdata;
			end
			if (wr_take && (i_paddr == `SMD_OFF_FLAGS)) begin
				flags_ff <= i_pwdata[4:0];
			end
			// Read data frozen here so it stands with pready
			if (state_ff[1]) begin
				prdata_ff <= is_rf ? rf_rdata : (is_csr ? csr_rdata : 32'h0000_0000);
			end
			// Count or old destination captured one cycle after its read
			if (state_ff[4]) begin
				aux_ff <= rf_rdata;
			end
			// Illegal encodings change nothing but the status
			if (state_ff[5]) begin
				done_ff    <= 1'b1;
				illegal_ff <= !legal;
				kind_ff    <= {k_fstore, k_aload, k_move, k_mshift, k_rshift};
				if (legal) begin
					result_ff <= ex_val;
					flags_ff  <= ex_flags;
				end
			end
		end
	end

endmodule // smd_decode

// ==== verilog/smd_regfile.v ====
// Register file of eight data and eight address registers, registered read
`timescale 1ns/1ps

module smd_regfile #(
	parameter WIDTH = 32,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	// Clock and reset
	input  wire             i_clk,
	input  wire             i_rst,
	// Write port
	input  wire             i_we,
	input  wire [AW-1:0]    i_waddr,
	input  wire [WIDTH-1:0] i_wdata,
	// Read port
	input  wire [AW-1:0]    i_raddr,
	output wire [WIDTH-1:0] o_rdata
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [WIDTH-1:0] rdata_ff;

	// ****************************************
	// Storage
	// ****************************************
	// Contents carry no reset; software loads them before use
	always @(posedge i_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
	end

	// Read data one cycle after the address
	always @(posedge i_clk) begin
		if (i_rst) begin
			rdata_ff <= {WIDTH{1'b0}};
		end else begin
			rdata_ff <= mem[i_raddr];
		end
	end

	assign o_rdata = rdata_ff;

endmodule // smd_regfile
